// >>> design/asat_pkg.sv
// Constants and types shared by the asynchronous static RAM host controller.
package asat_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int T_WP_NS       = 50;
	localparam int T_CW_NS       = 60;
	localparam int T_DW_NS       = 30;
	localparam int T_RC_NS       = 70;
	localparam int T_AA_NS       = 70;
	localparam int T_OE_NS       = 35;
	localparam int T_HZ_NS       = 25;
	localparam int WP_CYC   = (T_CW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
		(T_CW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RD_CYC   = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
		(T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAP_CYC  = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
		(T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RET_CYC  = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
		(T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W    = 4;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
	localparam logic [CNT_W-1:0] WP_CNT   = CNT_W'(WP_CYC);
	localparam logic [CNT_W-1:0] RD_CNT   = CNT_W'(RD_CYC);
	localparam logic [CNT_W-1:0] GAP_CNT  = CNT_W'(GAP_CYC);
	localparam logic [CNT_W-1:0] RET_CNT  = CNT_W'(RET_CYC);
	// Read data crosses the three-flop synchroniser, which needs two more cycles to settle.
	localparam int SYNC_CYC = 2;
	localparam logic [CNT_W-1:0] RD_WAIT_CNT = CNT_W'(RD_CYC + SYNC_CYC);
	localparam int LANE_HI_MSB = 15;
	localparam int LANE_HI_LSB = 8;
	localparam int LANE_LO_MSB = 7;
	localparam int LANE_LO_LSB = 0;
	typedef enum logic [3:0] {
		ASAT_IDLE, ASAT_W_SETUP, ASAT_W_PULSE, ASAT_W_END,
		ASAT_R_SETUP, ASAT_R_WAIT, ASAT_R_END, ASAT_GAP, ASAT_RET, ASAT_RET_EXIT
	} asat_state_t;
endpackage

// >>> design/asat_sync3.sv
// Three-stage synchroniser for a pin that arrives from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module asat_sync3 #(
	parameter int   W        = 1
) (
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	input  wire logic         clk_en,
	input  wire logic [W-1:0] pin,
	output var  logic [W-1:0] level
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	wire  [W-1:0] agree = ~(s2 ^ s3);
	wire  [W-1:0] next_level = (agree & s2) | (~agree & level);
	// The first stage feeds only the second; the level moves once stages two and three agree.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1    <= '0;
			s2    <= '0;
			s3    <= '0;
			level <= '0;
		end else if (clk_en) begin
			s1    <= pin;
			s2    <= s1;
			s3    <= s2;
			level <= next_level;
		end
	end
endmodule
`default_nettype wire

// >>> design/asat_timer.sv
// Down-counter that times one phase of a memory cycle.
`timescale 1ns/1ps
`default_nettype none
module asat_timer #(
	parameter int W = 4
) (
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	input  wire logic         clk_en,
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	output var  logic         done
);
	logic [W-1:0] count;
	wire          zero       = (count == '0);
	wire  [W-1:0] next_count = load ? value : (zero ? count : count - W'(1));
	assign done = zero && !load;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= '0;
		end else if (clk_en) begin
			count <= next_count;
		end
	end
endmodule
`default_nettype wire

// >>> design/asat_ctrl.sv
// Host-side controller that runs read, write and retention cycles on the static RAM pins.
`timescale 1ns/1ps
`default_nettype none
module asat_ctrl #(
	parameter int AW = 20,
	parameter int DW = 16
) (
	input  wire logic          core_clk,
	input  wire logic          rst_b,
	input  wire logic          clk_en,
	input  wire logic          req_valid,
	input  wire logic          req_write,
	input  wire logic [AW-1:0] req_addr,
	input  wire logic [DW-1:0] req_wdata,
	input  wire logic [1:0]    req_lanes,
	output logic               req_ready,
	output logic               rsp_valid,
	output logic [DW-1:0]      rsp_rdata,
	input  wire logic          retention_req,
	output logic               retention_ack,
	input  wire logic          bus_grant,
	output logic               busy,
	output logic [AW-1:0]      sram_addr,
	output logic               sram_select_low_b,
	output logic               sram_select_high,
	output logic               write_strobe_b,
	output logic               output_gate_b,
	output logic               upper_lane_select_b,
	output logic               lower_lane_select_b,
	output logic [DW-1:0]      data_out,
	output logic               data_oe_b,
	input  wire logic [DW-1:0] data_in
);
	import asat_pkg::*;

	default clocking assert_clk @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	asat_state_t     state;
	asat_state_t     next_state;
	logic            wr_cycle;
	logic [1:0]      lanes;
	logic [CNT_W-1:0] tmr_value;
	logic            tmr_load;
	wire             tmr_done;
	wire  [DW-1:0]   din_sync;
	wire             ret_sync;

	asat_sync3 #(.W(DW)) u_din_sync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.clk_en   (clk_en),
		.pin      (data_in),
		.level    (din_sync)
	);

	asat_sync3 #(.W(1)) u_ret_sync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.clk_en   (clk_en),
		.pin      (retention_req),
		.level    (ret_sync)
	);

	asat_timer #(.W(CNT_W)) u_timer (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.clk_en   (clk_en),
		.load     (tmr_load),
		.value    (tmr_value),
		.done     (tmr_done)
	);

	// Accept only when the shared bus has been granted to this memory. 
	wire idle_take   = (state == ASAT_IDLE) && req_valid && bus_grant && !ret_sync;
	wire idle_ret    = (state == ASAT_IDLE) && ret_sync;
	wire lanes_any   = |req_lanes;
	wire in_write    = (state == ASAT_W_SETUP) || (state == ASAT_W_PULSE) ||
		(state == ASAT_W_END);
	wire in_read     = (state == ASAT_R_SETUP) || (state == ASAT_R_WAIT) ||
		(state == ASAT_R_END);
	wire sel_on      = in_write || in_read;
	// Lanes are raised at the edges of a write so they never start or end the cycle.
	wire lane_drive  = (state == ASAT_W_PULSE) || in_read;
	wire strobe_on   = (state == ASAT_W_PULSE);
	wire gate_on     = (state == ASAT_R_WAIT) || (state == ASAT_R_END);
	// Data is driven only in write states, never while the gate may let the memory drive.
	wire drive_data  = in_write;
	wire ret_release = (state == ASAT_RET) && !ret_sync;

	always_comb begin
		next_state = state;
		tmr_load   = 1'b0;
		tmr_value  = CNT_ZERO;
		case (state)
			ASAT_IDLE: begin
				if (idle_ret) begin
					next_state = ASAT_RET;
				end else if (idle_take && lanes_any) begin
					next_state = req_write ? ASAT_W_SETUP : ASAT_R_SETUP;
				end
			end
			ASAT_W_SETUP: begin
				// Address and selects settle a full cycle before the strobe falls.
				next_state = ASAT_W_PULSE;
				tmr_load   = 1'b1;
				tmr_value  = WP_CNT;
			end
			ASAT_W_PULSE: begin
				if (tmr_done) begin
					next_state = ASAT_W_END;
				end
			end
			ASAT_W_END: begin
				next_state = ASAT_GAP;
				tmr_load   = 1'b1;
				tmr_value  = GAP_CNT;
			end
			ASAT_R_SETUP: begin
				next_state = ASAT_R_WAIT;
				tmr_load   = 1'b1;
				// The gate stays low until the captured data has passed the synchroniser.
				tmr_value  = RD_WAIT_CNT;
			end
			ASAT_R_WAIT: begin
				if (tmr_done) begin
					next_state = ASAT_R_END;
				end
			end
			ASAT_R_END: begin
				next_state = ASAT_GAP;
				tmr_load   = 1'b1;
				tmr_value  = GAP_CNT;
			end
			ASAT_GAP: begin
				if (tmr_done) begin
					next_state = ASAT_IDLE;
				end
			end
			ASAT_RET: begin
				if (ret_release) begin
					next_state = ASAT_RET_EXIT;
					tmr_load   = 1'b1;
					tmr_value  = RET_CNT;
				end
			end
			ASAT_RET_EXIT: begin
				if (tmr_done) begin
					next_state = ASAT_IDLE;
				end
			end
			default: begin
				next_state = ASAT_IDLE;
			end
		endcase
	end

	// Lane selects gate byte halves: bit 1 is the upper byte, bit 0 the lower.
	wire [DW-1:0] lane_mask = {{(DW/2){lanes[1]}}, {(DW/2){lanes[0]}}};
	wire [DW-1:0] next_rdata = (din_sync & lane_mask);
	wire          capture    = (state == ASAT_R_END);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ASAT_IDLE;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_cycle  <= 1'b0;
			lanes     <= 2'h0;
			sram_addr <= '0;
			data_out  <= '0;
		end else if (clk_en && idle_take && lanes_any && !idle_ret) begin
			wr_cycle  <= req_write;
			lanes     <= req_lanes;
			sram_addr <= req_addr;
			data_out  <= req_wdata;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sram_select_low_b   <= 1'b1;
			sram_select_high    <= 1'b0;
			write_strobe_b      <= 1'b1;
			output_gate_b       <= 1'b1;
			upper_lane_select_b <= 1'b1;
			lower_lane_select_b <= 1'b1;
			data_oe_b           <= 1'b1;
		end else if (clk_en) begin
			sram_select_low_b   <= !(next_state inside {ASAT_W_SETUP, ASAT_W_PULSE, ASAT_W_END,
				ASAT_R_SETUP, ASAT_R_WAIT, ASAT_R_END});
			// The high select is parked at ground in retention, never left floating.
			sram_select_high    <= next_state inside {ASAT_W_SETUP, ASAT_W_PULSE, ASAT_W_END,
				ASAT_R_SETUP, ASAT_R_WAIT, ASAT_R_END};
			write_strobe_b      <= !(next_state == ASAT_W_PULSE);
			output_gate_b       <= !(next_state inside {ASAT_R_WAIT, ASAT_R_END});
			upper_lane_select_b <= !((next_state == ASAT_W_PULSE ||
				next_state inside {ASAT_R_SETUP, ASAT_R_WAIT, ASAT_R_END}) &&
				(state == ASAT_IDLE ? req_lanes[1] : lanes[1]));
			lower_lane_select_b <= !((next_state == ASAT_W_PULSE ||
				next_state inside {ASAT_R_SETUP, ASAT_R_WAIT, ASAT_R_END}) &&
				(state == ASAT_IDLE ? req_lanes[0] : lanes[0]));
			data_oe_b           <= !(next_state inside {ASAT_W_SETUP, ASAT_W_PULSE, ASAT_W_END});
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rsp_valid     <= 1'b0;
			rsp_rdata     <= '0;
			req_ready     <= 1'b0;
			retention_ack <= 1'b0;
			busy          <= 1'b0;
		end else if (clk_en) begin
			rsp_valid     <= capture;
			if (capture) begin
				rsp_rdata <= next_rdata;
			end
			req_ready     <= (next_state == ASAT_IDLE) && !ret_sync;
			retention_ack <= (next_state == ASAT_RET);
			busy          <= (next_state != ASAT_IDLE);
		end
	end

	a_strobe_inside_sel: assert property (
		!write_strobe_b |-> (!sram_select_low_b && sram_select_high))
		else $error("Strobe low outside selected window.");
	a_pulse_width_min: assert property (
		$fell(write_strobe_b) |-> !write_strobe_b [*2])
		else $error("Write pulse shorter than two cycles.");
	a_sel_before_strobe: assert property (
		$fell(write_strobe_b) |-> $past(!sram_select_low_b && sram_select_high))
		else $error("Select not asserted before strobe fall.");
	a_addr_stable_wr: assert property (
		!write_strobe_b |-> $stable(sram_addr))
		else $error("Address moved during write.");
	a_data_before_end: assert property (
		$rose(write_strobe_b) |-> ($past(!data_oe_b) && $stable(data_out)))
		else $error("Write data not held up to write end.");
	a_lanes_off_edges: assert property (
		$fell(write_strobe_b) |-> $past(upper_lane_select_b && lower_lane_select_b))
		else $error("Lane select low at write start.");
	a_no_contention: assert property (
		!output_gate_b |-> data_oe_b)
		else $error("Host drives data while output gate low.");
	// A stalled clock enable keeps the response high, so only its first cycle is checked.
	a_read_access: assert property (
		$rose(rsp_valid) |-> $past(!output_gate_b && write_strobe_b))
		else $error("Read captured without gate.");
	a_retention_off: assert property (
		retention_ack |-> (sram_select_low_b && !sram_select_high))
		else $error("Select active during retention.");
	a_grant_needed: assert property (
		$fell(sram_select_low_b) |-> $past(bus_grant, 1))
		else $error("Memory enabled without bus grant.");
	// The decoded terms tie the strobe, gate, data enable and low select pins back to the state that should drive them.
	a_pins_follow_state: assert property (
		(write_strobe_b == !strobe_on) && (output_gate_b == !gate_on) &&
		(data_oe_b == !drive_data) && (sram_select_low_b == !sel_on))
		else $error("Pin levels disagree with the state decode.");
	a_lanes_in_cycle: assert property (
		(!upper_lane_select_b || !lower_lane_select_b) |-> lane_drive)
		else $error("Lane select low outside an access.");
	a_strobe_in_write: assert property (
		!write_strobe_b |-> wr_cycle)
		else $error("Strobe low during a read cycle.");
	a_write_end_clean: assert property (
		$rose(write_strobe_b) |-> (upper_lane_select_b && lower_lane_select_b &&
		!sram_select_low_b && sram_select_high && !data_oe_b))
		else $error("Write not ended by the strobe alone.");
	// Selects stay off long enough that consecutive cycles never crowd the memory.
	a_cycle_spacing: assert property (
		$rose(sram_select_low_b) |-> sram_select_low_b [*3])
		else $error("Memory cycles spaced too closely.");
	a_retention_exit: assert property (
		$fell(retention_ack) |-> sram_select_low_b [*2])
		else $error("Access started too soon after retention.");
	a_read_gate_cond: assert property (
		!output_gate_b |-> (!sram_select_low_b && sram_select_high && write_strobe_b &&
		!(upper_lane_select_b && lower_lane_select_b)))
		else $error("Output gate low without a full read setup.");

	c_write_done: cover property ($rose(write_strobe_b));
	c_read_done: cover property (rsp_valid);
	c_retention: cover property ($fell(retention_ack));
	c_stalled_read: cover property (rsp_valid && !clk_en);
endmodule
`default_nettype wire

// >>> tb/asat_sram_model.sv
// Behavioural static RAM on the far side of the controller, with host timing checks.
`timescale 1ns/1ps
`default_nettype none
module asat_sram_model (
	input  wire logic [19:0] sram_addr,
	input  wire logic        sram_select_low_b,
	input  wire logic        sram_select_high,
	input  wire logic        write_strobe_b,
	input  wire logic        output_gate_b,
	input  wire logic        upper_lane_select_b,
	input  wire logic        lower_lane_select_b,
	input  wire logic [15:0] data_out,
	input  wire logic        data_oe_b,
	output wire logic [15:0] data_in,
	output var  int          viol
);
	logic [15:0] mem [int];
	logic        cs;
	logic        wr;
	logic        drv_hi;
	logic        drv_lo;
	logic        clash;
	logic [15:0] rdata;
	logic [15:0] tmp;
	logic [1:0]  lane_seen;
	logic [19:0] wr_addr;
	int          wr_cnt = 0;
	realtime     t_ws = 0.0;
	realtime     t_cs = -1000.0;
	realtime     t_dat = 0.0;
	realtime     t_lane = 0.0;
	initial viol = 0;
	function automatic logic [15:0] peek(input logic [19:0] a);
		return mem.exists(int'(a)) ? mem[int'(a)] : 16'h0;
	endfunction
	assign cs = !sram_select_low_b && sram_select_high;
	assign wr = cs && !write_strobe_b;
	// The 20 ns inertial delay sits inside both the gate access and the release limits.
	assign #20 drv_hi = cs && write_strobe_b && !output_gate_b && !upper_lane_select_b;
	assign #20 drv_lo = cs && write_strobe_b && !output_gate_b && !lower_lane_select_b;
	always @(sram_addr or wr_cnt) rdata <= #10 peek(sram_addr);
	// A released lane shows the inverse of its data, so a stale capture cannot pass.
	assign data_in[15:8] = !data_oe_b ? data_out[15:8] : drv_hi ? rdata[15:8] : ~rdata[15:8];
	assign data_in[7:0] = !data_oe_b ? data_out[7:0] : drv_lo ? rdata[7:0] : ~rdata[7:0];
	assign clash = !data_oe_b && (drv_hi || drv_lo);
	always @(posedge clash) viol++;
	always @(posedge cs) begin
		if ($realtime - t_cs < 70.0) viol++;
		t_cs = $realtime;
	end
	always @(data_out or data_oe_b) t_dat = $realtime;
	always @(negedge upper_lane_select_b or negedge lower_lane_select_b) t_lane = $realtime;
	always @(upper_lane_select_b or lower_lane_select_b) begin
		if (wr) lane_seen = lane_seen | ~{upper_lane_select_b, lower_lane_select_b};
	end
	always @(posedge wr) begin
		t_ws = $realtime;
		wr_addr = sram_addr;
		lane_seen = ~{upper_lane_select_b, lower_lane_select_b};
	end
	always @(negedge wr) begin
		if ($realtime - t_ws < 50.0) viol++;
		if ($realtime - t_cs < 60.0) viol++;
		if (sram_addr !== wr_addr) viol++;
		if ($realtime - t_lane < 60.0) viol++;
		if ($realtime - t_dat < 30.0 || data_oe_b !== 1'b0) viol++;
		tmp = peek(wr_addr);
		if (lane_seen[1]) tmp[15:8] = data_in[15:8];
		if (lane_seen[0]) tmp[7:0] = data_in[7:0];
		mem[int'(wr_addr)] = tmp;
		wr_cnt++;
	end
endmodule
`default_nettype wire

// >>> tb/async_sram_access_timing_tb.sv
// Self-checking bench for the static RAM host controller with random traffic.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module async_sram_access_timing_tb;
	import asat_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        req_valid = 1'b0;
	logic        req_write = 1'b0;
	logic [19:0] req_addr = 20'h0;
	logic [15:0] req_wdata = 16'h0;
	logic [1:0]  req_lanes = 2'h3;
	logic        retention_req = 1'b0;
	logic        bus_grant = 1'b1;
	logic        clk_en = 1'b1;
	logic        stall_on = 1'b0;
	wire  logic  req_ready, rsp_valid, retention_ack, busy, data_oe_b;
	wire  logic  sram_select_low_b, sram_select_high, write_strobe_b, output_gate_b;
	wire  logic  upper_lane_select_b, lower_lane_select_b;
	wire  logic [15:0] rsp_rdata, data_out, data_in;
	wire  logic [19:0] sram_addr;
	int          viol;
	int          bad_count = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          seed = 31;
	int          i, n, hits;
	logic [31:0] r;
	logic [15:0] shadow [8];

	asat_ctrl i_dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.retention_req(retention_req), .retention_ack(retention_ack), .bus_grant(bus_grant),
		.busy(busy), .sram_addr(sram_addr), .sram_select_low_b(sram_select_low_b),
		.sram_select_high(sram_select_high), .write_strobe_b(write_strobe_b),
		.output_gate_b(output_gate_b), .upper_lane_select_b(upper_lane_select_b),
		.lower_lane_select_b(lower_lane_select_b), .data_out(data_out), .data_oe_b(data_oe_b),
		.data_in(data_in));
	asat_sram_model i_mem (.sram_addr(sram_addr), .sram_select_low_b(sram_select_low_b),
		.sram_select_high(sram_select_high), .write_strobe_b(write_strobe_b),
		.output_gate_b(output_gate_b), .upper_lane_select_b(upper_lane_select_b),
		.lower_lane_select_b(lower_lane_select_b), .data_out(data_out), .data_oe_b(data_oe_b),
		.data_in(data_in), .viol(viol));

	always #50 core_clk = ~core_clk;

	// Occasional clock-enable drops during random traffic check that the controller freezes.
	always @(posedge core_clk) begin
		#5;
		clk_en = !(stall_on && (cyc % 7 == 3));
	end

	function automatic logic [19:0] addr_of(input logic [2:0] k);
		return {k, 14'h0, k};
	endfunction

	task automatic tally_and_finish;
		$display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// The controller takes any granted request with a lane set that it sees while idle, so one is raised only once ready
	// shows, and held until ready drops, which marks the taking edge even across stalls.
	task automatic access(input logic wr, input logic [2:0] k, input logic [1:0] ln);
		logic [15:0] wd;
		logic [15:0] exp;
		int          w;
		wd = 16'($random(seed));
		exp = {ln[1] ? shadow[k][15:8] : 8'h00, ln[0] ? shadow[k][7:0] : 8'h00};
		for (w = 0; w < 40 && req_ready !== 1'b1; w++) begin
			@(posedge core_clk);
			#5;
		end
		req_valid = 1'b1;
		req_write = wr;
		req_addr = addr_of(k);
		req_wdata = wd;
		req_lanes = ln;
		for (w = 0; w < 40 && req_ready === 1'b1; w++) begin
			@(posedge core_clk);
			#5;
		end
		req_valid = 1'b0;
		if (wr) begin
			if (ln[1]) shadow[k][15:8] = wd[15:8];
			if (ln[0]) shadow[k][7:0] = wd[7:0];
		end else begin
			for (w = 0; w < 20 && rsp_valid !== 1'b1; w++) begin
				@(posedge core_clk);
				#1;
			end
			`CHK(rsp_valid, 1'b1)
			`CHK(rsp_rdata, exp)
			#4;
		end
	endtask

	// A request that must not be taken leaves the memory deselected.
	task automatic quiet(input int cnt, input logic [1:0] ln);
		hits = 0;
		req_valid = 1'b1;
		req_write = 1'b0;
		req_lanes = ln;
		repeat (cnt) begin
			@(posedge core_clk);
			#5;
			if (sram_select_low_b !== 1'b1) hits++;
		end
		req_valid = 1'b0;
		`CHK(hits, 0)
	endtask

	task automatic check_idle_pins;
		`CHK({sram_select_low_b, sram_select_high, write_strobe_b, output_gate_b}, 4'hb)
		`CHK({upper_lane_select_b, lower_lane_select_b, data_oe_b}, 3'h7)
	endtask

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			tally_and_finish;
		end
	end

	initial begin
		for (i = 0; i < 8; i++) shadow[i] = 16'h0;
		repeat (16) @(posedge core_clk);
		#5;
		check_idle_pins;
		rst_b = 1'b1;
		access(1'b1, 3'h3, 2'h3);
		access(1'b1, 3'h3, 2'h1);
		access(1'b1, 3'h3, 2'h2);
		access(1'b0, 3'h3, 2'h3);
		access(1'b0, 3'h3, 2'h2);
		access(1'b0, 3'h3, 2'h1);
		bus_grant = 1'b0;
		quiet(10, 2'h3);
		bus_grant = 1'b1;
		quiet(10, 2'h0);
		stall_on = 1'b1;
		for (i = 0; i < 60; i++) begin
			r = $random(seed);
			access(r[0], r[3:1], r[5:4] == 2'h0 ? 2'h3 : r[5:4]);
		end
		stall_on = 1'b0;
		retention_req = 1'b1;
		for (n = 0; n < 20 && retention_ack !== 1'b1; n++) begin
			@(posedge core_clk);
			#5;
		end
		`CHK(retention_ack, 1'b1)
		`CHK({sram_select_low_b, sram_select_high}, 2'h2)
		retention_req = 1'b0;
		hits = 0;
		for (n = 0; n < 30 && req_ready !== 1'b1; n++) begin
			@(posedge core_clk);
			#5;
			if (sram_select_low_b !== 1'b1) hits++;
		end
		`CHK(n >= RET_CYC, 1'b1)
		`CHK(hits, 0)
		access(1'b0, 3'h3, 2'h3);
		rst_b = 1'b0;
		repeat (3) @(posedge core_clk);
		#5;
		check_idle_pins;
		rst_b = 1'b1;
		access(1'b1, 3'h5, 2'h3);
		access(1'b0, 3'h5, 2'h3);
		`CHK(viol, 0)
		tally_and_finish;
	end
endmodule
`default_nettype wire
